/* shared/pwmtw_defines.vh */
`ifndef PWMTW_DEFINES_VH
`define PWMTW_DEFINES_VH
// Control byte
`define PWMTW_CTRL_CODE        4'h5
`define PWMTW_CTRL_CODE_MSB    7
`define PWMTW_CTRL_CODE_LSB    4
`define PWMTW_CTRL_SEL_MSB     3
`define PWMTW_CTRL_SEL_LSB     1
`define PWMTW_CTRL_RW_BIT      0
// Data byte fields
`define PWMTW_CMD_MSB          7
`define PWMTW_CMD_LSB          5
`define PWMTW_DUTY_MSB         4
`define PWMTW_DUTY_LSB         0
// Command field encodings
`define PWMTW_CMD_DUTY         3'h0
`define PWMTW_CMD_FULL         3'h1
`define PWMTW_CMD_SHDN         3'h2
`define PWMTW_CMD_RECALL       3'h4
// Reset values
`define PWMTW_DUTY_RESET       5'h10
// Timing
`define PWMTW_CLK_HZ           50000000
`define PWMTW_PWM_HZ           100000
`define PWMTW_PWM_STEPS        32
`define PWMTW_STEP_CYCLES      ((`PWMTW_CLK_HZ / `PWMTW_PWM_HZ) / `PWMTW_PWM_STEPS)
`endif

/* rtl/pwmtw_sync.v */
`timescale 1ns/1ps
`default_nettype none
module pwmtw_sync (
    input  wire mclk,
    input  wire resetn,
    input  wire async_in,
    output reg  sync_out
);
    reg meta_r;
    // Two-stage synchroniser, idle high
    always @(posedge mclk) begin
        if (!resetn) begin
            meta_r   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // pwmtw_sync
`default_nettype wire

/* rtl/pwmtw_mod.v */
`timescale 1ns/1ps
`default_nettype none
`include "pwmtw_defines.vh"
module pwmtw_mod #(
    parameter integer STEP_CYCLES = `PWMTW_STEP_CYCLES
) (
    input  wire       mclk,
    input  wire       resetn,
    input  wire [4:0] duty,
    input  wire       full_on,
    output reg        pwm_level
);
    reg [15:0] pre_r;
    reg [4:0]  step_r;
    reg [4:0]  duty_r;
    reg        full_r;
    wire       step_end = (pre_r == STEP_CYCLES - 1);
    always @(posedge mclk) begin
        if (!resetn) begin
            pre_r     <= 16'h0000;
            step_r    <= 5'h00;
            duty_r    <= `PWMTW_DUTY_RESET;
            full_r    <= 1'b0;
            pwm_level <= 1'b0;
        end else begin
            pre_r <= step_end ? 16'h0000 : pre_r + 16'h0001;
            if (step_end) begin
                step_r <= step_r + 5'h01;
                if (step_r == 5'h1f) begin
                    duty_r <= duty;
                    full_r <= full_on;
                end
            end
            pwm_level <= full_r | (step_r < duty_r);
        end
    end
endmodule // pwmtw_mod
`default_nettype wire

/* rtl/pwmtw_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "pwmtw_defines.vh"
module pwmtw_top #(
    parameter [2:0]   CMD_FULL    = `PWMTW_CMD_FULL,
    parameter [2:0]   CMD_SHDN    = `PWMTW_CMD_SHDN,
    parameter [2:0]   CMD_RECALL  = `PWMTW_CMD_RECALL,
    parameter integer SHDN_BIT    = 7,
    parameter integer STEP_CYCLES = `PWMTW_STEP_CYCLES
) (
    input  wire mclk,
    input  wire resetn,
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out,
    output reg  sda_oe,
    input  wire select_pin_bit0,
    input  wire select_pin_bit1,
    input  wire select_pin_bit2,
    output reg  pwm_out,
    output reg  pwm_oe
);
    ////////////////////////////////////////////////////////////////////////
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CTRL  = 3'h1;
    localparam [2:0] ST_WDATA = 3'h2;
    localparam [2:0] ST_RDATA = 3'h3;
    localparam [2:0] ST_RACK  = 3'h4;

    wire       scl_s;
    wire       sda_s;
    wire       sel0_s;
    wire       sel1_s;
    wire       sel2_s;
    reg        scl_d_r;
    reg        sda_d_r;
    reg  [2:0] state_r;
    reg  [3:0] bit_r;
    reg  [7:0] shift_r;
    reg        ack_r;
    reg  [4:0] duty_r;
    reg        full_r;
    reg        shdn_r;
    reg        addr_hit_r;
    wire       pwm_level;
    wire [7:0] cfg_byte;

    pwmtw_sync u_scl (.mclk(mclk), .resetn(resetn), .async_in(scl_in), .sync_out(scl_s));
    pwmtw_sync u_sda (.mclk(mclk), .resetn(resetn), .async_in(sda_in), .sync_out(sda_s));
    pwmtw_sync u_s0 (.mclk(mclk), .resetn(resetn), .async_in(select_pin_bit0), .sync_out(sel0_s));
    pwmtw_sync u_s1 (.mclk(mclk), .resetn(resetn), .async_in(select_pin_bit1), .sync_out(sel1_s));
    pwmtw_sync u_s2 (.mclk(mclk), .resetn(resetn), .async_in(select_pin_bit2), .sync_out(sel2_s));

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

    function [7:0] cfg_of;
        input [4:0] d;
        input       f;
        input       s;
        reg   [7:0] v;
        begin
            v = {3'h0, d};
            if (f)
                v[`PWMTW_CMD_MSB:`PWMTW_CMD_LSB] = CMD_FULL;
            v[SHDN_BIT] = s;
            cfg_of = v;
        end
    endfunction
    assign cfg_byte = cfg_of(duty_r, full_r, shdn_r);

    wire [7:0] rx_byte = {shift_r[6:0], sda_s};
    wire addr_hit = (rx_byte[`PWMTW_CTRL_CODE_MSB:`PWMTW_CTRL_CODE_LSB] == `PWMTW_CTRL_CODE)
                  && (rx_byte[`PWMTW_CTRL_SEL_MSB:`PWMTW_CTRL_SEL_LSB]
                      == {sel2_s, sel1_s, sel0_s});

    ////////////////////////////////////////////////////////////////////////
    // Link state machine
    always @(posedge mclk) begin
        if (!resetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= ST_IDLE;
            bit_r   <= 4'h0;
            shift_r <= 8'h00;
            ack_r   <= 1'b0;
            duty_r  <= `PWMTW_DUTY_RESET;
            full_r  <= 1'b0;
            shdn_r  <= 1'b0;
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (start_c) begin
                state_r <= ST_CTRL;
                bit_r   <= 4'h0;
                ack_r   <= 1'b0;
                sda_oe  <= 1'b0;
            end else if (stop_c) begin
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
            end else if (state_r != ST_IDLE) begin
                if (scl_rise && !ack_r && state_r != ST_RDATA && state_r != ST_RACK) begin
                    shift_r <= rx_byte;
                    bit_r   <= bit_r + 4'h1;
                end
                if (scl_rise && state_r == ST_RACK) begin
                    if (sda_s)
                        state_r <= ST_IDLE;
                    else
                        state_r <= ST_RDATA;
                    bit_r <= 4'h0;
                end
                if (scl_fall) begin
                    if (ack_r) begin
                        // Release after own ack
                        ack_r  <= 1'b0;
                        bit_r  <= 4'h0;
                        sda_oe <= 1'b0;
                        if (state_r == ST_RDATA) begin
                            sda_oe  <= ~cfg_byte[7];
                            shift_r <= {cfg_byte[6:0], 1'b0};
                            bit_r   <= 4'h1;
                        end
                    end else if (state_r == ST_RDATA) begin
                        if (bit_r == 4'h8) begin
                            sda_oe  <= 1'b0;
                            state_r <= ST_RACK;
                        end else if (bit_r == 4'h0) begin
                            // Reload after master ack
                            sda_oe  <= ~cfg_byte[7];
                            shift_r <= {cfg_byte[6:0], 1'b0};
                            bit_r   <= 4'h1;
                        end else begin
                            sda_oe  <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_r   <= bit_r + 4'h1;
                        end
                    end else if (bit_r == 4'h8) begin
                        if (state_r == ST_CTRL) begin
                            if (addr_hit_r) begin
                                ack_r  <= 1'b1;
                                sda_oe <= 1'b1;
                                state_r <= shift_r[`PWMTW_CTRL_RW_BIT] ? ST_RDATA : ST_WDATA;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            ack_r  <= 1'b1;
                            sda_oe <= 1'b1;
                            case (shift_r[`PWMTW_CMD_MSB:`PWMTW_CMD_LSB])
                                CMD_SHDN: begin
                                    shdn_r <= 1'b1;
                                end
                                CMD_RECALL: begin
                                    shdn_r <= 1'b0;
                                end
                                CMD_FULL: begin
                                    full_r <= 1'b1;
                                end
                                default: begin
                                    full_r <= 1'b0;
                                    duty_r <= shift_r[`PWMTW_DUTY_MSB:`PWMTW_DUTY_LSB];
                                end
                            endcase
                        end
                    end
                end
            end
        end
    end

    always @(posedge mclk) begin
        if (!resetn)
            addr_hit_r <= 1'b0;
        else if (scl_rise && bit_r == 4'h7)
            addr_hit_r <= addr_hit;
    end

    ////////////////////////////////////////////////////////////////////////
    // 104kHz modulator (32 steps of 15 clocks at 50MHz)
    pwmtw_mod #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_mod (
        .mclk      (mclk),
        .resetn    (resetn),
        .duty      (duty_r),
        .full_on   (full_r),
        .pwm_level (pwm_level)
    );

    always @(posedge mclk) begin
        if (!resetn) begin
            pwm_out <= 1'b0;
            pwm_oe  <= 1'b1;
        end else begin
            pwm_out <= pwm_level & ~shdn_r;
            pwm_oe  <= ~shdn_r;
        end
    end
endmodule // pwmtw_top
`default_nettype wire

/* dv/pwmtw_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmtw_checker #(
    parameter integer STEP_CYCLES = 2
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic pwm_out,
    input wire logic pwm_oe
);
    localparam integer PER = 32 * STEP_CYCLES;
    logic [15:0] gap_r;
    logic        prev_r;
    logic        seen_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Cycles since the last output rise
    always @(posedge mclk) begin
        prev_r <= resetn & pwm_out;
        gap_r  <= (pwm_out && !prev_r) ? 16'h1 : gap_r + 16'h1;
        seen_r <= resetn & (seen_r | (pwm_out & !prev_r));
    end
    open_drain_a: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    shdn_quiet_a: assert property (!pwm_oe |-> !pwm_out)
        else $error("output active in shutdown");
    sda_stable_a: assert property (scl_in && $past(scl_in, 3) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    ack_in_low_a: assert property ($rose(sda_oe) |-> !scl_in || $past(!scl_in))
        else $error("sda taken while scl high");
    ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
        else $error("sda pulse too short");
    release_low_a: assert property ($fell(sda_oe) |-> !scl_in || $past(!scl_in))
        else $error("sda released while scl high");
    oe_after_ack_a: assert property ($changed(pwm_oe) |->
        sda_oe || $past(sda_oe, 2) || $past(sda_oe, 4) || $past(sda_oe, 6))
        else $error("power state changed outside ack");
    pwm_period_a: assert property (pwm_out && !prev_r && seen_r |-> gap_r % PER == 0)
        else $error("output period wrong");
endmodule // pwmtw_checker
bind pwmtw_top pwmtw_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_i (.mclk(mclk), .resetn(resetn),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
`default_nettype wire

/* dv/pwmtw_master.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmtw_master (
    input  wire logic mclk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_lo
);
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    task automatic tick(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // one bit, open drain, sampled late in high phase
    task automatic bitx(input logic b, output logic r);
        @(posedge mclk) sda_lo <= !b;
        tick(3);
        scl <= 1'b1;
        tick(4);
        r = sda;
        scl <= 1'b0;
    endtask
    task automatic start();
        @(posedge mclk) sda_lo <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge mclk) sda_lo <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_lo <= 1'b0;
        tick(8);
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    // byte in, then ack or not
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!ack, r);
    endtask
endmodule // pwmtw_master
`default_nettype wire

/* dv/pwmtw_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pwmtw_top_tb;
    localparam integer STEP = 2;
    localparam integer PER  = 32 * STEP;
    logic       mclk, resetn, scl, m_lo, sda_out, sda_oe, pwm_out, pwm_oe;
    logic [2:0] sel;
    integer     err_total, total_checks;
    wire        sda = !(m_lo || (sda_oe && !sda_out));
    pwmtw_top #(.STEP_CYCLES(STEP)) uut (.mclk(mclk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel[0]),
        .select_pin_bit1(sel[1]), .select_pin_bit2(sel[2]), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe));
    pwmtw_master mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_lo(m_lo));
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic meas(output logic [7:0] n);
        n = 8'h0;
        repeat (2 * PER) @(posedge mclk);
        repeat (PER) begin
            @(posedge mclk);
            n = n + {7'h0, pwm_out};
        end
    endtask
    task automatic wtx(input logic [7:0] c, input logic [7:0] d, input logic [7:0] e);
        logic a0, a1;
        logic [7:0] n;
        mst.start();
        mst.wr(c, a0);
        mst.wr(d, a1);
        mst.stop();
        meas(n);
        chk(n, e);
    endtask
    task automatic rtx(input logic [7:0] e);
        logic a0;
        logic [7:0] d, d2;
        mst.start();
        mst.wr(8'h5b, a0);
        mst.rd(1'b1, d);
        mst.rd(1'b0, d2);
        mst.stop();
        chk({7'h0, a0}, 8'h1);
        chk(d, e);
        chk(d2, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] n;
        meas(n);
        chk(n, 8'(16 * STEP));
        rtx(8'h10);
        $display("test reset done");
    endtask
    task automatic t_duty();
        logic a0, a1, a2;
        logic [7:0] n;
        mst.start();
        mst.wr(8'h5a, a0);
        mst.wr(8'h00, a1);
        mst.wr(8'h1f, a2);
        mst.stop();
        chk({5'h0, a0, a1, a2}, 8'h7);
        meas(n);
        chk(n, 8'(31 * STEP));
        wtx(8'h5a, 8'h00, 8'h0);
        wtx(8'h5a, 8'h08, 8'(8 * STEP));
        rtx(8'h08);
        $display("test duty done");
    endtask
    task automatic t_full();
        wtx(8'h5a, 8'h28, 8'(PER));
        rtx(8'h28);
        wtx(8'h5a, 8'h04, 8'(4 * STEP));
        $display("test full done");
    endtask
    task automatic t_shdn();
        wtx(8'h5a, 8'h40, 8'h0);
        chk({7'h0, pwm_oe}, 8'h0);
        rtx(8'h84);
        wtx(8'h5a, 8'h80, 8'(4 * STEP));
        chk({7'h0, pwm_oe}, 8'h1);
        $display("test shutdown done");
    endtask
    task automatic t_addr();
        logic a0;
        for (int s = 0; s < 8; s++) begin
            sel <= s[2:0];
            mst.tick(4);
            mst.start();
            mst.wr({4'h5, s[2:0], 1'b0}, a0);
            mst.stop();
            chk({7'h0, a0}, 8'h1);
            mst.start();
            mst.wr({4'h5, ~s[2:0], 1'b0}, a0);
            mst.stop();
            chk({7'h0, a0}, 8'h0);
        end
        mst.start();
        mst.wr(8'h7e, a0);
        mst.stop();
        chk({7'h0, a0}, 8'h0);
        $display("test address done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        err_total = 0;
        total_checks = 0;
        resetn = 1'b0;
        sel = 3'h5;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_duty();
        t_full();
        t_shdn();
        t_addr();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        $display("CHECK FAILED %0t timeout", $time);
        final_report();
    end
endmodule // pwmtw_top_tb
`default_nettype wire
